// file: flash_suspend_bufprog_die_erase.sv
// APB-controlled host that drives a two-die parallel NOR flash bus
// How it works
// [R1] Suspend op writes B0h once to the selected die.
// [R2] While suspended, software may read any address; suspended word is invalid.
// [R3] Suspend is allowed inside erase suspend; host tracks only its own state, and refuses any suspend while its one suspended flag is set.
// [R4] Reads and other single cycles stay allowed while program is suspended.
// [R5] Hardware reset aborts a suspended program; reprogram flag is raised.
// [R6] Resume writes 30h; a second resume is refused until a new suspend.
// [R7] Poll op reads status twice and compares the toggle bit.
// [R8] Wide-buffer ops are refused unless word-wide bus mode is configured.
// [R9] In wide-buffer mode only its own ops, reads and polls are issued; the code also accepts hardware reset there.
// [R10] Exit issues two bus writes: 90h then 00h.
// [R11] Loads address the page latched at setup, low byte from a counter.
// [R12] Order: enter, setup, 256 loads, confirm, exit.
// [R13] Load addresses ascend from 00h to ffh.
// [R14] Loads always target the setup block and page.
// [R15] Confirm refused before 256 loads; extra loads refused.
// [R16] Abort bit seen while toggling sets the abort flag.
// [R17] Failure or abort bit triggers a recheck poll; resets clear flags (hardware reset here leaves the abort and failure flags set).
// [R18] Die erase issues six writes, die from the top address bit.
// [R19] A protected die still shows busy then done; poll handles both.
// [R20] During die erase the device answers reads with status.
// [R21] Read/reset op clears a failure after die erase.
// [R22] A second die erase is refused until polling shows the first done.
// [R23] Every command cycle carries the die select bit of the address.
// [R24] Suspend refused when already suspended; resume refused when not.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "flash_host_regs.svh"

module flash_suspend_bufprog_die_erase (
  input  wire logic        mclk,     // 20 MHz clock
  input  wire logic        rst,      // Async reset, active high
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error
  output logic      [24:0] fl_addr,  // Flash address
  output logic      [15:0] dq_out,   // Flash data out
  output logic             dq_oe,    // Flash data drive enable
  input  wire logic [15:0] dq_in,    // Flash data in
  output logic             ce_n,     // Chip enable, low
  output logic             oe_n,     // Output enable, low
  output logic             we_n,     // Write enable, low
  output logic             fl_rst_n, // Flash reset, low
  output logic             byte_n    // Low selects byte mode
);

  localparam int WE_CYC  = (`WE_PULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int RD_CYC  = (`READ_ACCESS_NS + `CLK_NS - 1) / `CLK_NS
                           + `SYNC_STAGES;
  localparam int RST_CYC = (`RESET_PULSE_NS + `CLK_NS - 1) / `CLK_NS;

  function automatic flash_host_pkg::bus_cycle_t seq_cycle(
    input flash_host_pkg::op_t op,
    input logic [2:0]          step,
    input logic [24:0]         addr,
    input logic [15:0]         wdata,
    input logic [16:0]         page,
    input logic [7:0]          idx
  );
    flash_host_pkg::bus_cycle_t c;
    logic                       die;
    die    = addr[24];
    c.addr = addr;
    c.data = wdata;
    c.rd   = 1'b0;
    case (op)
      flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL:
        c.rd = 1'b1;
      flash_host_pkg::OP_SUSPEND:
        c.data = `CMD_SUSPEND; // R1
      flash_host_pkg::OP_RESUME:
        c.data = `CMD_RESUME; // R6
      flash_host_pkg::OP_WIDE_SETUP:
        c.data = `CMD_WIDE_SETUP;
      flash_host_pkg::OP_WIDE_LOAD:
        c.addr = {page, idx}; // R11
      flash_host_pkg::OP_WIDE_CONFIRM:
        c = '{addr: {page, 8'h00}, data: `CMD_CONFIRM, rd: 1'b0};
      flash_host_pkg::OP_WIDE_EXIT: // R10
        c.data = (step == 3'd0) ? `CMD_WIDE_EXIT1 : `CMD_WIDE_EXIT2;
      flash_host_pkg::OP_READ_RESET:
        c.data = `CMD_READ_RESET;
      flash_host_pkg::OP_WIDE_ENTER, flash_host_pkg::OP_ABORT_RESET,
      flash_host_pkg::OP_DIE_ERASE:
      begin
        case (step)
          3'd0, 3'd3: c.addr = {die, `UNLOCK_ADDR1}; // R23
          3'd1, 3'd4: c.addr = {die, `UNLOCK_ADDR2};
          default:    c.addr = {die, `UNLOCK_ADDR1};
        endcase
        case (step)
          3'd0, 3'd3: c.data = `CMD_UNLOCK1;
          3'd1, 3'd4: c.data = `CMD_UNLOCK2;
          3'd5:       c.data = `CMD_DIE_ERASE; // R18
          default:
            c.data = (op == flash_host_pkg::OP_WIDE_ENTER) ? `CMD_WIDE_ENTER :
                     (op == flash_host_pkg::OP_ABORT_RESET) ? `CMD_ABORT_RST :
                     `CMD_ERASE_SETUP;
        endcase
      end
      default:
        c.rd = 1'b1;
    endcase
    return c;
  endfunction : seq_cycle

  flash_host_pkg::state_t     state;
  flash_host_pkg::op_t        cur_op;
  flash_host_pkg::bus_cycle_t cyc;
  logic [2:0]  step;
  logic [5:0]  cnt;
  logic [24:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [15:0] prev_data;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic [16:0] page;
  logic [8:0]  load_cnt;
  logic        word_mode;
  logic        refused;
  logic        abort_flag;
  logic        fail_flag;
  logic        dev_busy;
  logic        erase_busy;
  logic        suspended;
  logic        wide_mode;
  logic        loading;
  logic        reprog;
  logic        recheck;

  wire                      acc      = psel & penable & ~pready;
  wire                      wr_acc   = acc & pwrite;
  wire                      go       = wr_acc & (paddr == `REG_CTRL);
  wire                      clr_wr   = wr_acc & (paddr == `REG_STATUS);
  wire flash_host_pkg::op_t req_op   = flash_host_pkg::op_t'(pwdata[3:0]);
  wire                      wide_op  = (req_op >= flash_host_pkg::OP_WIDE_ENTER)
                                    && (req_op <= flash_host_pkg::OP_ABORT_RESET);
  wire                      plain_rd = (req_op == flash_host_pkg::OP_READ)
                                    || (req_op == flash_host_pkg::OP_POLL);
  wire                      known_op = (req_op <= flash_host_pkg::OP_HW_RESET);
  wire                      mode_ok  = (!wide_op || word_mode)            // R8
                                    && (!wide_mode || wide_op || plain_rd
                                        || req_op == flash_host_pkg::OP_HW_RESET); // R9
  wire                      seq_ok   =
    (req_op == flash_host_pkg::OP_WIDE_SETUP)   ? wide_mode && !loading :
    (req_op == flash_host_pkg::OP_WIDE_LOAD)    ? loading && load_cnt < `WIDE_WORDS : // R15
    (req_op == flash_host_pkg::OP_WIDE_CONFIRM) ? loading && load_cnt == `WIDE_WORDS : // R12
    (req_op == flash_host_pkg::OP_SUSPEND)      ? !suspended :             // R24
    (req_op == flash_host_pkg::OP_RESUME)       ? suspended :              // R6
    (req_op == flash_host_pkg::OP_DIE_ERASE)    ? !erase_busy : 1'b1;      // R22
  wire                      accept   = go && state == flash_host_pkg::S_IDLE
                                    && known_op && mode_ok && seq_ok; // R4
  wire [2:0]                seq_len  =
    (cur_op == flash_host_pkg::OP_DIE_ERASE)   ? 3'd6 :
    (cur_op == flash_host_pkg::OP_WIDE_ENTER ||
     cur_op == flash_host_pkg::OP_ABORT_RESET) ? 3'd3 :
    (cur_op == flash_host_pkg::OP_POLL ||
     cur_op == flash_host_pkg::OP_WIDE_EXIT)   ? 3'd2 : 3'd1;
  wire                      toggled  = prev_data[`BIT_TOGGLE]
                                     ^ rdata_reg[`BIT_TOGGLE]; // R7
  wire                      poll_end = state == flash_host_pkg::S_FINISH
                                    && cur_op == flash_host_pkg::OP_POLL;
  wire                      rerun    = poll_end && toggled && !recheck
                                    && (rdata_reg[`BIT_ABORT]
                                    || rdata_reg[`BIT_FAILURE]); // R17
  wire                      fin      = state == flash_host_pkg::S_FINISH && !rerun;
  wire [31:0]               status   = {7'h00, load_cnt, 6'h00, reprog, loading,
                                        wide_mode, suspended, erase_busy,
                                        dev_busy, fail_flag, abort_flag,
                                        refused,
                                        state != flash_host_pkg::S_IDLE};
  wire [31:0]               rd_mux   =
    (paddr == `REG_CTRL)   ? {28'h0000000, cur_op} :
    (paddr == `REG_ADDR)   ? {7'h00, addr_reg} :
    (paddr == `REG_WDATA)  ? {16'h0000, wdata_reg} :
    (paddr == `REG_STATUS) ? status :
    (paddr == `REG_RDATA)  ? {16'h0000, rdata_reg} :
    {31'h00000000, word_mode};
  wire                      mapped   = paddr <= `REG_CONFIG && paddr[1:0] == 2'b00;

  assign cyc = seq_cycle(cur_op, step, addr_reg, wdata_reg, page, load_cnt[7:0]);

  // One wait state keeps all APB outputs registered
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= (acc & ~pwrite & mapped) ? rd_mux : 32'h00000000;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      addr_reg  <= 25'h0000000;
      wdata_reg <= 16'h0000;
      word_mode <= 1'b0;
      byte_n    <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == `REG_ADDR)
        addr_reg <= pwdata[24:0];
      if (wr_acc && paddr == `REG_WDATA)
        wdata_reg <= pwdata[15:0];
      if (wr_acc && paddr == `REG_CONFIG)
        word_mode <= pwdata[0];
      byte_n <= word_mode;
    end

  // Data pins come from the flash, so two stages first
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end
    else
    begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      state     <= flash_host_pkg::S_IDLE;
      cur_op    <= flash_host_pkg::OP_READ;
      step      <= 3'd0;
      cnt       <= 6'd0;
      fl_addr   <= 25'h0000000;
      dq_out    <= 16'h0000;
      dq_oe     <= 1'b0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
      fl_rst_n  <= 1'b1;
      rdata_reg <= 16'h0000;
      prev_data <= 16'h0000;
      recheck   <= 1'b0;
    end
    else
    begin
      case (state)
        flash_host_pkg::S_IDLE:
          if (accept)
          begin
            cur_op <= req_op;
            step   <= 3'd0;
            cnt    <= 6'(RST_CYC);
            state  <= (req_op == flash_host_pkg::OP_HW_RESET) ?
                      flash_host_pkg::S_RESET : flash_host_pkg::S_SETUP;
          end
        flash_host_pkg::S_SETUP:
        begin
          fl_addr <= cyc.addr;
          dq_out  <= cyc.data;
          dq_oe   <= ~cyc.rd;
          ce_n    <= 1'b0;
          cnt     <= cyc.rd ? 6'(RD_CYC - 1) : 6'(WE_CYC - 1);
          state   <= flash_host_pkg::S_STROBE;
        end
        flash_host_pkg::S_STROBE:
        begin
          oe_n <= ~cyc.rd;
          we_n <= cyc.rd;
          if (cnt == 6'd0 && !oe_n && cyc.rd)
          begin
            prev_data <= rdata_reg;
            rdata_reg <= dq_sync;
            state     <= flash_host_pkg::S_HOLD;
          end
          else if (cnt == 6'd0 && !we_n)
            state <= flash_host_pkg::S_HOLD;
          else if (!oe_n || !we_n)
            cnt <= cnt - 6'd1;
        end
        flash_host_pkg::S_HOLD:
        begin
          oe_n  <= 1'b1;
          we_n  <= 1'b1;
          ce_n  <= 1'b1;
          dq_oe <= 1'b0;
          step  <= step + 3'd1;
          state <= (step + 3'd1 == seq_len) ? flash_host_pkg::S_FINISH :
                   flash_host_pkg::S_SETUP;
        end
        flash_host_pkg::S_FINISH:
        begin
          recheck <= rerun;
          step    <= 3'd0;
          state   <= rerun ? flash_host_pkg::S_SETUP : flash_host_pkg::S_IDLE;
        end
        flash_host_pkg::S_RESET:
        begin
          fl_rst_n <= 1'b0;
          if (cnt == 6'd0)
          begin
            fl_rst_n <= 1'b1;
            state    <= flash_host_pkg::S_IDLE;
          end
          else
            cnt <= cnt - 6'd1;
        end
        default:
          state <= flash_host_pkg::S_IDLE;
      endcase
    end

  // Flags track what the host has told the flash; set beats clear
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      refused    <= 1'b0;
      abort_flag <= 1'b0;
      fail_flag  <= 1'b0;
      dev_busy   <= 1'b0;
      erase_busy <= 1'b0;
      suspended  <= 1'b0;
      wide_mode  <= 1'b0;
      loading    <= 1'b0;
      reprog     <= 1'b0;
      page       <= 17'h00000;
      load_cnt   <= 9'h000;
    end
    else
    begin
      if (go && !accept)
        refused <= 1'b1;
      else if (clr_wr && pwdata[`ST_REFUSED])
        refused <= 1'b0;
      if (state == flash_host_pkg::S_RESET && cnt == 6'd0)
      begin
        reprog     <= suspended; // R5
        suspended  <= 1'b0;
        wide_mode  <= 1'b0;
        loading    <= 1'b0;
        erase_busy <= 1'b0;
        dev_busy   <= 1'b0;
      end
      else if (clr_wr && pwdata[`ST_REPROG])
        reprog <= 1'b0;
      if (fin)
        case (cur_op)
          flash_host_pkg::OP_POLL:
          begin
            dev_busy <= toggled;          // R19
            if (!toggled)
              erase_busy <= 1'b0;         // R22
            if (toggled && rdata_reg[`BIT_ABORT])
              abort_flag <= 1'b1;         // R16
            else if (toggled && rdata_reg[`BIT_FAILURE])
              fail_flag <= 1'b1;          // R17
          end
          flash_host_pkg::OP_SUSPEND:      suspended <= 1'b1; // R3
          flash_host_pkg::OP_RESUME:       suspended <= 1'b0;
          flash_host_pkg::OP_WIDE_ENTER:   wide_mode <= 1'b1; // R9
          flash_host_pkg::OP_WIDE_SETUP:
          begin
            loading  <= 1'b1;
            load_cnt <= 9'h000;           // R13
            page     <= addr_reg[24:8];   // R14
          end
          flash_host_pkg::OP_WIDE_LOAD:    load_cnt <= load_cnt + 9'h001;
          flash_host_pkg::OP_WIDE_CONFIRM:
          begin
            loading  <= 1'b0;
            dev_busy <= 1'b1;
          end
          flash_host_pkg::OP_WIDE_EXIT:
          begin
            wide_mode <= 1'b0;
            loading   <= 1'b0;
          end
          flash_host_pkg::OP_ABORT_RESET:
          begin
            abort_flag <= 1'b0;
            loading    <= 1'b0;
            dev_busy   <= 1'b0;
            wide_mode  <= 1'b0;
          end
          flash_host_pkg::OP_DIE_ERASE:
          begin
            erase_busy <= 1'b1;           // R20
            dev_busy   <= 1'b1;
          end
          flash_host_pkg::OP_READ_RESET:
          begin
            fail_flag <= 1'b0;            // R21
            dev_busy  <= 1'b0;
            erase_busy <= 1'b0;
          end
          default:
            dev_busy <= dev_busy;         // R2
        endcase
    end

endmodule : flash_suspend_bufprog_die_erase

// file: flash_host_regs.svh
// Register offsets, field positions, command codes and timing values in nanoseconds
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0c
`define REG_RDATA       8'h10
`define REG_CONFIG      8'h14

`define ST_BUSY         0
`define ST_REFUSED      1
`define ST_ABORT        2
`define ST_FAIL         3
`define ST_DEV_BUSY     4
`define ST_ERASE_BUSY   5
`define ST_SUSPENDED    6
`define ST_WIDE_MODE    7
`define ST_LOADING      8
`define ST_REPROG       9
`define ST_LOAD_CNT_LO  16

`define BIT_DATA_POLL   7
`define BIT_TOGGLE      6
`define BIT_FAILURE     5
`define BIT_ABORT       1

`define CMD_UNLOCK1     16'h00aa
`define CMD_UNLOCK2     16'h0055
`define CMD_SUSPEND     16'h00b0
`define CMD_RESUME      16'h0030
`define CMD_WIDE_ENTER  16'h0038
`define CMD_WIDE_SETUP  16'h0033
`define CMD_CONFIRM     16'h0029
`define CMD_WIDE_EXIT1  16'h0090
`define CMD_WIDE_EXIT2  16'h0000
`define CMD_ABORT_RST   16'h00f0
`define CMD_ERASE_SETUP 16'h0080
`define CMD_DIE_ERASE   16'h0010
`define CMD_READ_RESET  16'h00f0
`define UNLOCK_ADDR1    24'h000555
`define UNLOCK_ADDR2    24'h0002aa

`define WIDE_WORDS      9'h100
`define CLK_NS          50
`define WE_PULSE_NS     35
`define READ_ACCESS_NS  80
`define RESET_PULSE_NS  500
`define SYNC_STAGES     2

`endif

// file: flash_host_pkg.sv
// Types shared by the flash host controller
package flash_host_pkg;

  typedef enum logic [3:0] {
    OP_READ, OP_POLL, OP_SUSPEND, OP_RESUME, OP_WIDE_ENTER, OP_WIDE_SETUP,
    OP_WIDE_LOAD, OP_WIDE_CONFIRM, OP_WIDE_EXIT, OP_ABORT_RESET,
    OP_DIE_ERASE, OP_READ_RESET, OP_HW_RESET
  } op_t;

  typedef struct packed {
    logic [24:0] addr;
    logic [15:0] data;
    logic        rd;
  } bus_cycle_t;

  typedef enum {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_FINISH, S_RESET
  } state_t;

endpackage : flash_host_pkg

// file: flash_host_checker.sv
// Protocol assertions for the flash host controller
`timescale 1ns/100ps
module flash_host_checker (
  input wire logic        mclk,     // Clock
  input wire logic        rst,      // Reset
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB enable
  input wire logic [7:0]  paddr,    // APB address
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire logic [24:0] fl_addr,  // Flash address
  input wire logic [15:0] dq_out,   // Flash data out
  input wire logic        dq_oe,    // Data drive
  input wire logic        ce_n,     // Chip enable
  input wire logic        oe_n,     // Output enable
  input wire logic        we_n,     // Write strobe
  input wire logic        fl_rst_n  // Flash reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_READY_PULSE:
    assert property (pready |=> !pready)
    else $error("pready stood more than one cycle");
  AST_ONE_WAIT:
    assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait");
  AST_UNMAPPED:
    assert property (pready && (paddr > 8'h14 || paddr[1:0] != 2'h0)
      |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  AST_STROBE_QUAL:
    assert property (!we_n |-> !ce_n && dq_oe && oe_n)
    else $error("write strobe without chip enable and data");
  AST_STROBE_ONE:
    assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe not two cycles long");
  AST_ADDR_HELD:
    assert property ($fell(we_n) |-> $stable(fl_addr)
      ##1 $stable(fl_addr) && $stable(dq_out))
    else $error("address or data moved during strobe");
  AST_NO_CLASH:
    assert property (!oe_n |-> !dq_oe && !ce_n && we_n)
    else $error("host drives data during a read");
  AST_READ_LEN:
    assert property ($fell(oe_n) |-> !oe_n[*2])
    else $error("read strobe shorter than access time");
  AST_RESET_PULSE:
    assert property ($fell(fl_rst_n) |-> (!fl_rst_n && ce_n)[*8])
    else $error("flash reset pulse too short");

  cover property ($fell(we_n));
  cover property (pready && pslverr);
  cover property ($fell(fl_rst_n));
  cover property ($fell(oe_n));
endmodule : flash_host_checker

// file: flash_dev_model.sv
// Behavioural two-die flash device facing the host controller
`timescale 1ns/100ps
module flash_dev_model (
  input  wire logic [24:0] fl_addr,  // Address
  input  wire logic [15:0] dq_host,  // Resolved data wire
  input  wire logic        ce_n,     // Chip enable
  input  wire logic        oe_n,     // Output enable
  input  wire logic        we_n,     // Write strobe
  input  wire logic        fl_rst_n, // Reset
  input  wire logic        byte_n,   // Word mode
  input  wire logic [1:0]  fault,    // 1 erase fails, 2 buffer aborts
  output logic      [15:0] dq_dev,   // Data to host
  output logic      [1:0]  erased    // Dies erased
);
  logic [15:0] mem [256];
  logic [15:0] rv, last, wd;
  logic [24:0] wa;
  logic [47:0] hist;
  logic [5:0]  hdie;
  logic [16:0] page;
  logic        wide, load, abort, fail, ers, susp, tgl, wsel, die;
  int          busy, idx;
  // Released bus shows the inverse, never a stale copy
  assign dq_dev = (!ce_n && !oe_n) ? rv : ~last;
  initial erased = 2'h0;
  always @(negedge fl_rst_n or posedge wide or negedge wide)
    if (!fl_rst_n)
    begin
      {wide, load, abort, fail, ers, susp, tgl} = 7'h0;
      busy = 0;
      hist = 48'h0;
      page = '1;
    end
  initial
  begin
    {wide, load, abort, fail, ers, susp, tgl} = 7'h0;
    {busy, hist, page, rv, last} = '0;
    page = '1;
  end
  always @(negedge we_n)
  begin
    wsel = !ce_n;
    wa = fl_addr;
    wd = dq_host;
  end
  always @(posedge we_n)
    if (wsel && !ers)
    begin
      hist = {hist[39:0], wd[7:0]};
      hdie = {hdie[4:0], wa[24]};
      if (load && idx < 256)
      begin
        if (wa[24:8] != page || wa[7:0] != idx[7:0])
          {abort, load} = 2'b10;
        mem[idx[7:0]] = wd;
        idx++;
      end
      else if (load)
      begin
        load = 0;
        if (wd[7:0] != 8'h29 || fault == 2'd2) abort = 1;
        else busy = 3;
      end
      else if (wd[7:0] == 8'hf0) {abort, fail, wide} = 3'h0;
      else if (wd[7:0] == 8'h30 && susp) susp = 0;
      else if (wd[7:0] == 8'hb0 && busy > 0) susp = 1;
      else if (hist[23:0] == 24'haa5538 && byte_n) wide = 1;
      else if (wide && wd[7:0] == 8'h33)
      begin
        {load, idx, page} = {1'b1, 32'h0, wa[24:8]};
      end
      else if (wide && hist[15:0] == 16'h9000) wide = 0;
      else if (hist == 48'haa5580aa5510 && hdie == {6{wa[24]}})
      begin
        {ers, die, busy} = {1'b1, wa[24], 32'h3};
      end
    end
  always @(negedge oe_n)
  begin
    #1;
    if (busy > 0 && !susp || abort || fail)
    begin
      tgl = !tgl;
      rv = {9'h0, tgl, fail, 3'h0, abort, 1'b0};
      if (busy > 0 && !abort) busy--;
      if (busy == 0 && ers)
      begin
        ers = 0;
        if (fault == 2'd1) fail = 1;
        else erased[die] = 1'b1;
      end
    end
    else rv = (fl_addr[24:8] == page) ? mem[fl_addr[7:0]] : fl_addr[15:0];
  end
  always @(posedge oe_n) last = rv;
endmodule : flash_dev_model

// file: tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "flash_host_regs.svh"
module tb;
  localparam logic [31:0] RF = 32'h1 << `ST_REFUSED;
  localparam logic [31:0] AB = 32'h1 << `ST_ABORT;
  localparam logic [31:0] FL = 32'h1 << `ST_FAIL;
  localparam logic [31:0] DB = 32'h1 << `ST_DEV_BUSY;
  localparam logic [31:0] EB = 32'h1 << `ST_ERASE_BUSY;
  localparam logic [31:0] SP = 32'h1 << `ST_SUSPENDED;
  localparam logic [31:0] WM = 32'h1 << `ST_WIDE_MODE;
  localparam logic [31:0] RP = 32'h1 << `ST_REPROG;
  logic        mclk = 0, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic        dq_oe, ce_n, oe_n, we_n, fl_rst_n, byte_n;
  logic [24:0] fl_addr, page_a;
  logic [15:0] dq_out, dq_in, dq_dev, wd [256];
  logic [1:0]  fault, erased;
  logic [63:0] exp_q [$], e;
  int          err_total, cmp_count, cyc;
  integer      seed;
  assign dq_in = dq_oe ? dq_out : dq_dev;
  flash_suspend_bufprog_die_erase DUT (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .fl_rst_n(fl_rst_n), .byte_n(byte_n));
  flash_dev_model dev (.fl_addr(fl_addr), .dq_host(dq_in), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .fl_rst_n(fl_rst_n), .byte_n(byte_n),
    .fault(fault), .dq_dev(dq_dev), .erased(erased));
  always #25 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total = err_total + 1;
      close_out();
    end
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[31:0] != 32'h0)
      begin
        cmp_count = cmp_count + 1;
        if ((prdata & e[31:0]) !== e[63:32])
        begin
          err_total = err_total + 1;
          $display("wrong value at %0t: got %h expected %h", $time,
            prdata & e[31:0], e[63:32]);
        end
      end
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
    exp_q.push_back({x, m});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic st(input logic [31:0] x, m);
    rd(`REG_STATUS, x, m);
  endtask : st
  task automatic clr();
    apb(1'b1, `REG_STATUS, RF | RP);
  endtask : clr
  // Numeric op codes follow the op_t order
  task automatic op(input logic [3:0] o);
    apb(1'b1, `REG_CTRL, {28'h0, o});
    for (int i = 0; i < 3000; i++)
    begin
      rd(`REG_STATUS, 32'h0, 32'h0);
      if (rd_val[`ST_BUSY] === 1'b0) break;
    end
  endtask : op
  task automatic settle();
    for (int i = 0; i < 50; i++)
    begin
      op(4'd1);
      if (rd_val[`ST_DEV_BUSY] === 1'b0) break;
    end
  endtask : settle
  task automatic loads();
    for (int i = 0; i < 256; i++)
    begin
      wd[i] = 16'($random(seed));
      apb(1'b1, `REG_WDATA, {16'h0, wd[i]});
      op(4'd6);
    end
  endtask : loads
  task automatic close_out();
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    seed = 32'h8fb9a176;
    {rst, psel, penable, pwrite, paddr, pwdata, fault} = {1'b1, 45'h0};
    {err_total, cmp_count, cyc} = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    st(32'h0, 32'h01ff03ff);
    rd(`REG_CONFIG, 32'h0, 32'h1);
    rd(8'h18, 32'h0, 32'hffffffff);
    rd(8'h06, 32'h0, 32'hffffffff);
    op(4'd4);
    st(RF, RF | WM);
    clr();
    op(4'd3);
    st(RF, RF | SP);
    clr();
    op(4'd2);
    op(4'd0);
    st(SP, SP | RF);
    op(4'd2);
    st(SP | RF, SP | RF);
    clr();
    op(4'd3);
    st(32'h0, SP | RF);
    op(4'd3);
    st(RF, SP | RF);
    clr();
    op(4'd2);
    op(4'd12);
    st(RP, RP | SP);
    clr();
    st(32'h0, RP);
    apb(1'b1, `REG_CONFIG, 32'h1);
    op(4'd4);
    st(WM, WM | RF);
    op(4'd11);
    st(WM | RF, WM | RF);
    clr();
    page_a = 25'($random(seed)) & 25'h1ffff00;
    apb(1'b1, `REG_ADDR, {7'h0, page_a});
    op(4'd5);
    op(4'd7);
    st(RF, RF);
    clr();
    loads();
    st(32'h1000000, 32'h01ff0000 | RF);
    op(4'd6);
    st(RF, RF);
    clr();
    op(4'd7);
    settle();
    st(32'h0, AB | FL | DB);
    op(4'd8);
    st(32'h0, WM);
    for (int i = 0; i < 256; i += 85)
    begin
      apb(1'b1, `REG_ADDR, {7'h0, page_a | 25'(i)});
      op(4'd0);
      rd(`REG_RDATA, {16'h0, wd[i]}, 32'hffff);
    end
    fault = 2'd2;
    op(4'd4);
    op(4'd5);
    loads();
    op(4'd7);
    settle();
    st(AB, AB | FL);
    op(4'd9);
    st(32'h0, AB | WM);
    fault = 2'd0;
    apb(1'b1, `REG_ADDR, 32'h01000000);
    op(4'd10);
    st(EB, EB);
    op(4'd10);
    st(RF | EB, RF | EB);
    clr();
    settle();
    st(32'h0, EB | FL);
    if (erased !== 2'b10)
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h expected %h", $time, erased, 2'h2);
    end
    fault = 2'd1;
    apb(1'b1, `REG_ADDR, 32'h0);
    op(4'd10);
    settle();
    st(FL, FL);
    op(4'd11);
    st(32'h0, FL | EB);
    close_out();
  end
endmodule : tb
bind flash_suspend_bufprog_die_erase flash_host_checker chk (.mclk(mclk),
  .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
  .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .fl_rst_n(fl_rst_n));
